// *** hw/ctr_pkg.sv ***
// Package for the tag-store controller: pin bundles, commands and timing constants.
package ctr_pkg;

   // ==========================================
   // Geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;

   // ==========================================
   // Timing in ns, and cycles at 200 MHz
   localparam int CLK_PERIOD_NS = 5;
   localparam int WRITE_PULSE_MIN_NS = 7;
   localparam int ADDR_TO_WRITE_END_NS = 7;
   localparam int WRITE_CYCLE_MIN_NS = 8;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 5;
   localparam int WRITE_TO_OUTPUT_OFF_NS = 5;
   localparam int ADDRESS_ACCESS_TIME_NS = 8;
   localparam int ADDRESS_TO_HIT_VALID_NS = 8;
   localparam int CLEAR_PULSE_MIN_NS = 30;
   localparam int POWERUP_CLEAR_MIN_NS = 100;
   localparam int WE_HIGH_TO_CLEAR_END_NS = 5;
   localparam int CLEAR_END_TO_WE_LOW_NS = 25;

   function automatic int ceilCycles(input int ns);
      ceilCycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (ceilCycles < 1)
      begin
         ceilCycles = 1;
      end
   endfunction : ceilCycles

   // Write low time covers both the pulse minimum and output turn-off plus data set-up.
   localparam int WP_A = ceilCycles(WRITE_PULSE_MIN_NS);
   localparam int WP_B = ceilCycles(WRITE_TO_OUTPUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS);
   localparam int WRITE_LOW_CYC = (WP_A > WP_B) ? WP_A : WP_B;
   localparam int WRITE_CYC = ceilCycles(WRITE_CYCLE_MIN_NS);
   localparam int ACCESS_CYC = ceilCycles(ADDRESS_ACCESS_TIME_NS);
   localparam int HIT_CYC = ceilCycles(ADDRESS_TO_HIT_VALID_NS);
   localparam int CLEAR_CYC_A = ceilCycles(CLEAR_PULSE_MIN_NS);
   localparam int POWERUP_CYC = ceilCycles(POWERUP_CLEAR_MIN_NS);
   localparam int CLEAR_LOW_CYC = (POWERUP_CYC > CLEAR_CYC_A) ? POWERUP_CYC : CLEAR_CYC_A;
   localparam int CLEAR_SETUP_CYC = ceilCycles(WE_HIGH_TO_CLEAR_END_NS);
   localparam int CLEAR_RECOV_CYC = ceilCycles(CLEAR_END_TO_WE_LOW_NS);
   // Clear duty cycle at most 10 percent: low time times nine of guaranteed high time.
   localparam int CLEAR_DUTY_CYC = 9 * CLEAR_LOW_CYC;

   localparam logic [5:0] CNT_ZERO = 6'h00;

   // ==========================================
   // Commands
   typedef enum logic [1:0]
   {
      CTR_CMD_READ    = 2'b00,
      CTR_CMD_WRITE   = 2'b01,
      CTR_CMD_COMPARE = 2'b10,
      CTR_CMD_CLEAR   = 2'b11
   } ctr_cmd_type;

   typedef struct packed
   {
      ctr_cmd_type             cmd;
      logic [ADDR_W-1:0]       wordAddress;
      logic [DATA_W-1:0]       tagData;
   } ctr_req_type;

   typedef struct packed
   {
      logic                    hit;
      logic [DATA_W-1:0]       readData;
   } ctr_rsp_type;

   // Control pins toward the tag store, all active low.
   typedef struct packed
   {
      logic                    chipSelect_n;
      logic                    writeEnable_n;
      logic                    outputEnable_n;
      logic                    clear_n;
   } ctr_ctl_type;

endpackage : ctr_pkg

// *** hw/ctr_tag_ctrl.sv ***
// Controller that drives a cache-tag store with comparator through its pins.
`timescale 1ns/10ps
module ctr_tag_ctrl
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire ctr_pkg::ctr_req_type  reqData,
   input  wire logic                  reqValid,
   output logic                       reqReady,
   output ctr_pkg::ctr_rsp_type       rspData,
   output logic                       rspValid,
   output logic [ctr_pkg::ADDR_W-1:0] wordAddress,
   output logic [ctr_pkg::DATA_W-1:0] tagDataOut,
   output logic                       tagDataOe,
   input  wire logic [ctr_pkg::DATA_W-1:0] tagDataIn,
   input  wire logic                  hitIn,
   output ctr_pkg::ctr_ctl_type       pinCtl
);

   // ==========================================
   // State
   typedef enum logic [2:0]
   {
      CTR_ST_IDLE   = 3'b000,
      CTR_ST_WRLOW  = 3'b001,
      CTR_ST_WRREC  = 3'b010,
      CTR_ST_WAIT   = 3'b011,
      CTR_ST_CLRLOW = 3'b100,
      CTR_ST_CLRREC = 3'b101,
      CTR_ST_GAP    = 3'b110
   } ctr_state_type;

   ctr_state_type                state_reg, state_next;
   logic [5:0]                   cnt_reg, cnt_next;
   logic [8:0]                   gap_reg, gap_next;
   ctr_pkg::ctr_cmd_type         cmd_reg, cmd_next;
   logic [ctr_pkg::ADDR_W-1:0]   addr_reg, addr_next;
   logic [ctr_pkg::DATA_W-1:0]   dout_reg, dout_next;
   logic                         doe_reg, doe_next;
   ctr_pkg::ctr_ctl_type         ctl_reg, ctl_next;
   ctr_pkg::ctr_rsp_type         rsp_reg, rsp_next;
   logic                         rspv_reg, rspv_next;
   logic                         rdy_reg, rdy_next;
   logic [ctr_pkg::DATA_W-1:0]   dinSync1_reg, dinSync2_reg;
   logic                         hitSync1_reg, hitSync2_reg;

   // ==========================================
   // Elaboration check of the cycle counts against the counter widths
   if (ctr_pkg::CLEAR_LOW_CYC + ctr_pkg::CLEAR_RECOV_CYC > 63 ||
       ctr_pkg::ACCESS_CYC + 2 > 63 || ctr_pkg::HIT_CYC + 2 > 63 ||
       ctr_pkg::WRITE_LOW_CYC > 63 || ctr_pkg::WRITE_CYC < ctr_pkg::WRITE_LOW_CYC ||
       ctr_pkg::CLEAR_DUTY_CYC > 511)
   begin : g_countCheck
      $error("Timing counts exceed counter widths.");
   end

   // ==========================================
   // Pin input synchronisers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dinSync1_reg <= 8'h00;
         dinSync2_reg <= 8'h00;
         hitSync1_reg <= 1'b1;
         hitSync2_reg <= 1'b1;
      end
      else
      begin
         dinSync1_reg <= tagDataIn;
         dinSync2_reg <= dinSync1_reg;
         hitSync1_reg <= hitIn;
         hitSync2_reg <= hitSync1_reg;
      end
   end

   // ==========================================
   // Sequencer
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      gap_next   = (gap_reg != 9'h000) ? gap_reg - 9'h001 : gap_reg;
      cmd_next   = cmd_reg;
      addr_next  = addr_reg;
      dout_next  = dout_reg;
      doe_next   = doe_reg;
      ctl_next   = ctl_reg;
      rsp_next   = rsp_reg;
      rspv_next  = 1'b0;
      rdy_next   = 1'b0;
      unique case (state_reg)
         CTR_ST_IDLE:
         begin
            rdy_next = 1'b1;
            if (reqValid && rdy_reg)
            begin
               rdy_next  = 1'b0;
               cmd_next  = reqData.cmd;
               // Address moves only with write enable high and select high.
               addr_next = reqData.wordAddress;
               dout_next = reqData.tagData;
               unique case (reqData.cmd)
                  ctr_pkg::CTR_CMD_WRITE:
                  begin
                     // Data driven from pulse start; select and write fall together.
                     doe_next = 1'b1;
                     ctl_next.outputEnable_n = 1'b1;
                     ctl_next.chipSelect_n   = 1'b0;
                     ctl_next.writeEnable_n  = 1'b0;
                     cnt_next   = 6'(ctr_pkg::WRITE_LOW_CYC);
                     state_next = CTR_ST_WRLOW;
                  end
                  ctr_pkg::CTR_CMD_READ:
                  begin
                     doe_next = 1'b0;
                     ctl_next.chipSelect_n   = 1'b0;
                     ctl_next.outputEnable_n = 1'b0;
                     // Wait for address access plus input synchroniser.
                     cnt_next   = 6'(ctr_pkg::ACCESS_CYC + 2);
                     state_next = CTR_ST_WAIT;
                  end
                  ctr_pkg::CTR_CMD_COMPARE:
                  begin
                     // Compare mode: selected, write and output enable high.
                     doe_next = 1'b1;
                     ctl_next.chipSelect_n   = 1'b0;
                     ctl_next.outputEnable_n = 1'b1;
                     cnt_next   = 6'(ctr_pkg::HIT_CYC + 2);
                     state_next = CTR_ST_WAIT;
                  end
                  default:
                  begin
                     if (gap_reg == 9'h000)
                     begin
                        ctl_next.clear_n = 1'b0;
                        cnt_next   = 6'(ctr_pkg::CLEAR_LOW_CYC);
                        state_next = CTR_ST_CLRLOW;
                     end
                     else
                     begin
                        state_next = CTR_ST_GAP;
                     end
                  end
               endcase
            end
         end
         CTR_ST_GAP:
         begin
            if (gap_reg == 9'h000)
            begin
               ctl_next.clear_n = 1'b0;
               cnt_next   = 6'(ctr_pkg::CLEAR_LOW_CYC);
               state_next = CTR_ST_CLRLOW;
            end
         end
         CTR_ST_WRLOW:
         begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
               // Both rise together; recovery runs from that edge.
               ctl_next.writeEnable_n = 1'b1;
               ctl_next.chipSelect_n  = 1'b1;
               doe_next   = 1'b0;
               cnt_next   = 6'(ctr_pkg::WRITE_CYC - ctr_pkg::WRITE_LOW_CYC + 1);
               state_next = CTR_ST_WRREC;
            end
         end
         CTR_ST_WRREC:
         begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
               rspv_next  = 1'b1;
               state_next = CTR_ST_IDLE;
            end
         end
         CTR_ST_WAIT:
         begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
               rsp_next.readData = dinSync2_reg;
               // Released line reads high, meaning equal.
               rsp_next.hit = hitSync2_reg;
               rspv_next = 1'b1;
               ctl_next.chipSelect_n   = 1'b1;
               ctl_next.outputEnable_n = 1'b1;
               doe_next   = 1'b0;
               state_next = CTR_ST_IDLE;
            end
         end
         CTR_ST_CLRLOW:
         begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
               // Write enable has stayed high throughout the clear.
               ctl_next.clear_n = 1'b1;
               cnt_next   = 6'(ctr_pkg::CLEAR_RECOV_CYC);
               gap_next   = 9'(ctr_pkg::CLEAR_DUTY_CYC);
               state_next = CTR_ST_CLRREC;
            end
         end
         CTR_ST_CLRREC:
         begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01)
            begin
               rspv_next  = 1'b1;
               state_next = CTR_ST_IDLE;
            end
         end
         default:
         begin
            state_next = CTR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Power-up clear starts at reset; store begins all zeros.
         state_reg <= CTR_ST_CLRLOW;
         cnt_reg   <= 6'(ctr_pkg::CLEAR_LOW_CYC);
         gap_reg   <= 9'h000;
         cmd_reg   <= ctr_pkg::CTR_CMD_CLEAR;
         addr_reg  <= 13'h0000;
         dout_reg  <= 8'h00;
         doe_reg   <= 1'b0;
         ctl_reg   <= 4'b1110;
         rsp_reg   <= 9'h000;
         rspv_reg  <= 1'b0;
         rdy_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         gap_reg   <= gap_next;
         cmd_reg   <= cmd_next;
         addr_reg  <= addr_next;
         dout_reg  <= dout_next;
         doe_reg   <= doe_next;
         ctl_reg   <= ctl_next;
         rsp_reg   <= rsp_next;
         rspv_reg  <= rspv_next;
         rdy_reg   <= rdy_next;
      end
   end

   assign reqReady    = rdy_reg;
   assign rspData     = rsp_reg;
   assign rspValid    = rspv_reg;
   assign wordAddress = addr_reg;
   assign tagDataOut  = dout_reg;
   assign tagDataOe   = doe_reg;
   assign pinCtl      = ctl_reg;

endmodule : ctr_tag_ctrl

// *** dv/ctr_tag_monitor.sv ***
// Checker of the controller pin timing toward the tag store.
`timescale 1ns/10ps
module ctr_tag_monitor
(
   input wire logic                       clk,
   input wire logic                       arst_n,
   input wire logic                       rspValid,
   input wire logic [ctr_pkg::ADDR_W-1:0] wordAddress,
   input wire logic [ctr_pkg::DATA_W-1:0] tagDataOut,
   input wire logic                       tagDataOe,
   input wire ctr_pkg::ctr_ctl_type       pinCtl
);
   // ==========================================
   // Clear low and high time counters
   logic [7:0] lowCnt_reg, lowCnt_next, gapCnt_reg, gapCnt_next;
   wire logic sel_n = pinCtl.chipSelect_n;
   wire logic we_n = pinCtl.writeEnable_n;
   wire logic oe_n = pinCtl.outputEnable_n;
   wire logic clr_n = pinCtl.clear_n;
   always_comb
   begin
      lowCnt_next = clr_n ? 8'h00 : lowCnt_reg + {7'h00, ~&lowCnt_reg};
      gapCnt_next = clr_n ? gapCnt_reg + {7'h00, ~&gapCnt_reg} : 8'h00;
   end
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) {lowCnt_reg, gapCnt_reg} <= 16'h0000;
      else {lowCnt_reg, gapCnt_reg} <= {lowCnt_next, gapCnt_next};
   // ==========================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_writeHeld;
      !we_n [*2];
   endsequence
   sequence s_clearRecover;
      we_n [*5];
   endsequence
   a_write_pulse_len: assert property ($fell(we_n) |-> s_writeHeld)
      else $error("write pulse too short");
   a_addr_steady_write: assert property (!we_n |=> we_n || $stable(wordAddress))
      else $error("address moved inside a write");
   a_data_setup_write: assert property ($rose(we_n) |-> $past(tagDataOe)
      && $past(tagDataOut) == $past(tagDataOut, 2))
      else $error("write data not set up");
   a_write_drives_bus: assert property (!we_n |-> tagDataOe && !sel_n)
      else $error("write without data or select");
   a_no_bus_fight: assert property (!oe_n && !sel_n && we_n |-> !tagDataOe)
      else $error("bus driven during read");
   a_read_answer: assert property ($fell(oe_n) |-> (!oe_n) [*4] ##[1:2] rspValid)
      else $error("read access cut short");
   a_compare_drive: assert property (!sel_n && we_n && oe_n && clr_n |-> tagDataOe)
      else $error("compare with floating data");
   a_clear_len: assert property ($rose(clr_n) |-> lowCnt_reg >= ctr_pkg::CLEAR_LOW_CYC)
      else $error("clear pulse too short");
   a_clear_recover: assert property ($rose(clr_n) |-> $past(we_n) ##0 s_clearRecover)
      else $error("write enable near clear end");
   a_clear_duty: assert property ($fell(clr_n) |->
      gapCnt_reg + 8'h01 >= ctr_pkg::CLEAR_DUTY_CYC)
      else $error("clear duty cycle exceeded");
endmodule : ctr_tag_monitor
bind ctr_tag_ctrl ctr_tag_monitor ctr_tag_monitor_i
(
   .clk         (clk),
   .arst_n      (arst_n),
   .rspValid    (rspValid),
   .wordAddress (wordAddress),
   .tagDataOut  (tagDataOut),
   .tagDataOe   (tagDataOe),
   .pinCtl      (pinCtl)
);

// *** dv/ctr_tag_store_model.sv ***
// Behavioural tag store with comparator and pulled-up open-drain hit line.
`timescale 1ns/10ps
module ctr_tag_store_model
(
   input  wire logic [12:0]          wordAddress,
   input  wire logic [7:0]           tagDataOut,
   input  wire logic                 tagDataOe,
   input  wire ctr_pkg::ctr_ctl_type pinCtl,
   output logic [7:0]                tagDataIn,
   output logic                      hitIn
);
   logic [7:0]  mem [8192];
   logic [7:0]  readData, lastBus, wrData;
   logic [12:0] wrAddr;
   logic        active, devOe, writing;
   assign active = !pinCtl.chipSelect_n && pinCtl.clear_n;
   assign writing = active && !pinCtl.writeEnable_n;
   assign devOe = active && pinCtl.writeEnable_n && !pinCtl.outputEnable_n;
   assign #4 readData = mem[wordAddress];
   // An undriven bus shows the inverse of its last value, never a stale copy.
   assign tagDataIn = tagDataOe ? tagDataOut : devOe ? readData : ~lastBus;
   assign #3 hitIn = !(active && pinCtl.writeEnable_n && pinCtl.outputEnable_n
                       && mem[wordAddress] !== tagDataIn);
   always @*
      if (tagDataOe) lastBus = tagDataOut;
      else if (devOe) lastBus = readData;
   // Data is taken only while the controller drives it, so the zero-hold end of write
   // cannot latch the released bus level.
   always @*
      if (writing && tagDataOe)
      begin
         wrAddr = wordAddress;
         wrData = tagDataOut;
      end
   always @(negedge writing) mem[wrAddr] = wrData;
   always @(negedge pinCtl.clear_n) foreach (mem[i]) mem[i] = 8'h00;
endmodule : ctr_tag_store_model

// *** dv/testbench.sv ***
// Self-checking testbench of the tag-store controller.
`timescale 1ns/10ps
module testbench;
   logic                 clk, arst_n, reqValid, reqReady, rspValid, tagDataOe, hitIn;
   ctr_pkg::ctr_req_type reqData;
   ctr_pkg::ctr_rsp_type rspData, rsp;
   ctr_pkg::ctr_ctl_type pinCtl;
   logic [12:0]          wordAddress, a;
   logic [7:0]           tagDataOut, tagDataIn, d, expMem [8192];
   int                   failures, checks, lat, cyc, t0;
   ctr_tag_ctrl ctr_tag_ctrl_i (.clk(clk), .arst_n(arst_n), .reqData(reqData),
      .reqValid(reqValid), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
      .wordAddress(wordAddress), .tagDataOut(tagDataOut), .tagDataOe(tagDataOe),
      .tagDataIn(tagDataIn), .hitIn(hitIn), .pinCtl(pinCtl));
   ctr_tag_store_model ctr_tag_store_model_i (.wordAddress(wordAddress),
      .tagDataOut(tagDataOut), .tagDataOe(tagDataOe), .pinCtl(pinCtl),
      .tagDataIn(tagDataIn), .hitIn(hitIn));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc++;
   // ==========================================
   // Tasks
   function automatic logic expHit(input logic [12:0] ea, input logic [7:0] ed);
      return expMem[ea] === ed;
   endfunction : expHit
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("unexpected at %0t ns: %s", $time, msg);
      end
   endtask : check
   task automatic run(input ctr_pkg::ctr_cmd_type c, input logic [12:0] ra, input logic [7:0] rd);
      int n;
      n = 0;
      reqData = '{cmd: c, wordAddress: ra, tagData: rd};
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && n < 500)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      reqValid = 1'b0;
      lat = 0;
      while (rspValid !== 1'b1 && lat < 500)
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      rsp = rspData;
      if (c == ctr_pkg::CTR_CMD_WRITE) expMem[ra] = rd;
      if (c == ctr_pkg::CTR_CMD_CLEAR) foreach (expMem[i]) expMem[i] = 8'h00;
      check(n < 500 && lat < 500, "request not answered");
   endtask : run
   task automatic readBack(input logic [12:0] ra);
      run(ctr_pkg::CTR_CMD_READ, ra, 8'h00);
      check(rsp.readData === expMem[ra], "read data differs");
   endtask : readBack
   task automatic compare(input logic [12:0] ra, input logic [7:0] rd);
      run(ctr_pkg::CTR_CMD_COMPARE, ra, rd);
      check(rsp.hit === expHit(ra, rd), "hit result differs");
   endtask : compare
   // ==========================================
   // Main sequence
   initial
   begin
      failures = 0;
      checks = 0;
      cyc = 0;
      arst_n = 1'b0;
      reqValid = 1'b0;
      reqData = '0;
      void'($urandom(32'haf90));
      foreach (expMem[i]) expMem[i] = 8'h00;
      repeat (5) @(posedge clk);
      #1;
      arst_n = 1'b1;
      readBack(13'h1234);
      compare(13'h1fff, 8'h00);
      $display("test powerup done");
      for (int k = 0; k < 24; k++)
      begin
         a = (k == 0) ? 13'h0000 : (k == 1) ? 13'h1fff : 13'($urandom);
         d = (k == 2) ? 8'hff : 8'($urandom);
         if (k % 3 == 0) run(ctr_pkg::CTR_CMD_WRITE, a, ~d);
         run(ctr_pkg::CTR_CMD_WRITE, a, d);
         readBack(a);
         compare(a, d);
         compare(a, d ^ (8'h01 << (k % 8)));
      end
      readBack(13'h0000);
      $display("test write read compare done");
      run(ctr_pkg::CTR_CMD_CLEAR, 13'h0000, 8'h00);
      t0 = cyc;
      readBack(a);
      compare(a, 8'h00);
      run(ctr_pkg::CTR_CMD_CLEAR, 13'h0000, 8'h00);
      check(cyc - t0 >= ctr_pkg::CLEAR_DUTY_CYC + ctr_pkg::CLEAR_LOW_CYC, "clears too close");
      run(ctr_pkg::CTR_CMD_WRITE, a, 8'h5a);
      compare(a, 8'h5a);
      $display("test clear done");
      finish_test();
   end
   initial
   begin
      #200000;
      failures++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      finish_test();
   end
endmodule : testbench
